// [src/data_memory_sfr_decode.v]
// data memory routing, special register decode and external bus driver
`timescale 1ns/1ns
`include "data_memory_sfr_decode_map.vh"

module data_memory_sfr_decode (
    input wire sys_clk,
    input wire resetn,
    // core access to scratchpad and special registers
    input wire [7:0] mem_addr,
    input wire mem_direct,
    input wire mem_rd,
    input wire mem_wr,
    input wire [7:0] mem_wdata,
    input wire mem_bit,
    input wire [2:0] mem_bit_sel,
    output reg [7:0] mem_rdata,
    output reg mem_rvalid,
    // core data move port
    input wire xmov_req,
    input wire xmov_wr,
    input wire [15:0] xmov_addr,
    input wire [7:0] xmov_wdata,
    output wire xmov_busy,
    output reg xmov_done,
    output reg [7:0] xmov_rdata,
    output reg xmov_onchip,
    // code space port
    input wire code_rd,
    input wire code_we,
    input wire [1:0] code_bank,
    input wire [15:0] code_addr,
    input wire [7:0] code_wdata,
    output reg [7:0] code_rdata,
    // register contents seen by the core
    output wire [7:0] stack_pointer,
    output wire [15:0] data_pointer,
    // external multiplexed bus pins
    input wire [7:0] port0_in,
    output reg [7:0] port0_out,
    output reg [7:0] port0_oe,
    output reg [7:0] p2_out,
    output reg [7:0] p2_oe,
    output reg ale,
    output reg rd_n,
    output reg wr_n,
    output wire port0_pullup_enable
);

    // storage
    reg [7:0] scratch_mem [0:`SCRATCH_WORDS-1];
    reg [7:0] xram_mem [0:`XRAM_WORDS-1];
    reg [7:0] app_flash_bank_a [0:`CODE_BANK_WORDS-1];
    reg [7:0] app_flash_bank_b [0:`CODE_BANK_WORDS-1];
    reg [7:0] loader_flash_bank [0:`LOADER_WORDS-1];

    // special registers
    reg [7:0] port0_latch_r;
    reg [7:0] stack_pointer_r;
    reg [7:0] data_pointer_low_r;
    reg [7:0] data_pointer_high_r;
    reg [2:0] external_data_move_stretch_select_r;
    reg onchip_xram_enable_r;
    reg port0_pullup_enable_r;

    // port 0 input synchroniser and filter
    reg [7:0] port0_s1_r;
    reg [7:0] port0_s2_r;
    reg [7:0] port0_s3_r;
    reg [7:0] port0_filt_r;
    wire [7:0] port0_filt_nxt;

    // data move sequencer
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [5:0] cnt_r;
    reg [5:0] cnt_nxt;
    reg [5:0] total_r;
    reg [5:0] total_nxt;
    reg [15:0] mv_addr_r;
    reg [7:0] mv_data_r;
    reg mv_wr_r;

    // register access decode
    reg [7:0] sfr_val;
    reg sfr_hit;
    reg [7:0] wr_val;
    wire sfr_space;
    wire bit_ok;
    wire wr_ok;

    assign stack_pointer = stack_pointer_r;
    assign data_pointer = {data_pointer_high_r, data_pointer_low_r};
    assign port0_pullup_enable = port0_pullup_enable_r;
    assign xmov_busy = (state_r != `ST_IDLE);

    // upper half goes to registers only when addressed directly
    assign sfr_space = mem_addr[`SFR_SPACE_BIT] & mem_direct;
    assign bit_ok = sfr_space & ((mem_addr[3:0] == `BIT_NIBBLE_A) |
                                 (mem_addr[3:0] == `BIT_NIBBLE_B));
    assign wr_ok = mem_wr & (~mem_bit | bit_ok);

    // register read mux, missing bits and locations read high
    always @* begin
        sfr_hit = 1'b1;
        case (mem_addr)
            `SFR_PORT0_ADDR: sfr_val = mem_bit ? port0_latch_r : port0_filt_r;
            `SFR_STACK_ADDR: sfr_val = stack_pointer_r;
            `SFR_DPTR_LO_ADDR: sfr_val = data_pointer_low_r;
            `SFR_DPTR_HI_ADDR: sfr_val = data_pointer_high_r;
            `SFR_CLKCTL_ADDR: sfr_val = {5'h1F, external_data_move_stretch_select_r};
            `SFR_AUXPORT_ADDR: sfr_val = {7'h7F, port0_pullup_enable_r};
            `SFR_MEMMODE_ADDR: sfr_val = {7'h7F, onchip_xram_enable_r};
            default: begin
                sfr_hit = 1'b0;
                sfr_val = `UNIMPL_READ;
            end
        endcase
    end

    // single-bit write touches only the chosen bit
    always @* begin
        wr_val = mem_wdata;
        if (mem_bit) begin
            wr_val = sfr_val;
            wr_val[mem_bit_sel] = mem_wdata[0];
        end
    end

    // register writes
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            port0_latch_r <= `PORT0_RST;
            stack_pointer_r <= `STACK_RST;
            data_pointer_low_r <= `DPTR_RST;
            data_pointer_high_r <= `DPTR_RST;
            external_data_move_stretch_select_r <= `STRETCH_RST;
            onchip_xram_enable_r <= 1'b0;
            port0_pullup_enable_r <= 1'b0;
        end else if (wr_ok && sfr_space) begin
            case (mem_addr)
                `SFR_PORT0_ADDR: port0_latch_r <= wr_val;
                `SFR_STACK_ADDR: stack_pointer_r <= wr_val;
                `SFR_DPTR_LO_ADDR: data_pointer_low_r <= wr_val;
                `SFR_DPTR_HI_ADDR: data_pointer_high_r <= wr_val;
                `SFR_CLKCTL_ADDR: external_data_move_stretch_select_r <= wr_val[`STRETCH_MSB:0];
                `SFR_AUXPORT_ADDR: port0_pullup_enable_r <= wr_val[`PULLUP_EN_BIT];
                `SFR_MEMMODE_ADDR: onchip_xram_enable_r <= wr_val[`XRAM_EN_BIT];
                default: begin
                end
            endcase
        end
    end

    // scratchpad takes lower half and every indirect byte access; bit accesses never reach it
    always @(posedge sys_clk) begin
        if (wr_ok && !sfr_space && !mem_bit) begin
            scratch_mem[mem_addr] <= mem_wdata;
        end
    end

    // read answer one clock after the request
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            mem_rdata <= 8'h00;
            mem_rvalid <= 1'b0;
        end else begin
            mem_rvalid <= mem_rd;
            if (mem_rd) begin
                if (mem_bit) begin
                    mem_rdata <= {7'h00, bit_ok ? sfr_val[mem_bit_sel] : 1'b1};
                end else if (sfr_space) begin
                    mem_rdata <= sfr_val;
                end else begin
                    mem_rdata <= scratch_mem[mem_addr];
                end
            end
        end
    end

    // code space, banks selected by the core
    always @(posedge sys_clk) begin
        if (code_we) begin
            case (code_bank)
                `BANK_APP_A: app_flash_bank_a[code_addr] <= code_wdata;
                `BANK_APP_B: app_flash_bank_b[code_addr] <= code_wdata;
                `BANK_LOADER: loader_flash_bank[code_addr[`LOADER_AW-1:0]] <= code_wdata;
                default: begin
                end
            endcase
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            code_rdata <= 8'h00;
        end else if (code_rd) begin
            case (code_bank)
                `BANK_APP_A: code_rdata <= app_flash_bank_a[code_addr];
                `BANK_APP_B: code_rdata <= app_flash_bank_b[code_addr];
                `BANK_LOADER: code_rdata <= loader_flash_bank[code_addr[`LOADER_AW-1:0]];
                default: code_rdata <= `UNIMPL_READ;
            endcase
        end
    end

    // port 0 pins pass three flops, a change counts once two agree
    assign port0_filt_nxt = (~(port0_s2_r ^ port0_s3_r) & port0_s3_r) |
                            ((port0_s2_r ^ port0_s3_r) & port0_filt_r);
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_port0_sync
            always @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    port0_s1_r[gi] <= 1'b1;
                    port0_s2_r[gi] <= 1'b1;
                    port0_s3_r[gi] <= 1'b1;
                    port0_filt_r[gi] <= 1'b1;
                end else begin
                    port0_s1_r[gi] <= port0_in[gi];
                    port0_s2_r[gi] <= port0_s1_r[gi];
                    port0_s3_r[gi] <= port0_s2_r[gi];
                    port0_filt_r[gi] <= port0_filt_nxt[gi];
                end
            end
        end
    endgenerate

    // sequencer next state; route fixed on the request edge
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        total_nxt = total_r;
        case (state_r)
            `ST_IDLE: begin
                cnt_nxt = 6'h00;
                if (xmov_req) begin
                    if (onchip_xram_enable_r && (xmov_addr <= `XRAM_TOP)) begin
                        state_nxt = `ST_INT;
                        total_nxt = `INT_MOVE_MCYCLES * `MCYCLE_CLKS;
                    end else begin
                        state_nxt = `ST_EXT;
                        total_nxt = (`EXT_BASE_MCYCLES + {3'h0, external_data_move_stretch_select_r})
                                    * `MCYCLE_CLKS;
                    end
                end
            end
            `ST_INT, `ST_EXT: begin
                if (cnt_r == total_r - 6'h01) begin
                    state_nxt = `ST_IDLE;
                    cnt_nxt = 6'h00;
                end else begin
                    cnt_nxt = cnt_r + 6'h01;
                end
            end
            default: begin
                state_nxt = `ST_IDLE;
                cnt_nxt = 6'h00;
            end
        endcase
    end

    // sequencer state and move results
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= `ST_IDLE;
            cnt_r <= 6'h00;
            total_r <= 6'h00;
            mv_addr_r <= 16'h0000;
            mv_data_r <= 8'h00;
            mv_wr_r <= 1'b0;
            xmov_done <= 1'b0;
            xmov_rdata <= 8'h00;
            xmov_onchip <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            total_r <= total_nxt;
            xmov_done <= 1'b0;
            if (state_r == `ST_IDLE && xmov_req) begin
                mv_addr_r <= xmov_addr;
                mv_data_r <= xmov_wdata;
                mv_wr_r <= xmov_wr;
                xmov_onchip <= (state_nxt == `ST_INT);
            end
            if (state_r != `ST_IDLE && state_nxt == `ST_IDLE) begin
                xmov_done <= 1'b1;
                if (!mv_wr_r) begin
                    if (state_r == `ST_INT) begin
                        xmov_rdata <= xram_mem[mv_addr_r[`XRAM_AW-1:0]];
                    end else begin
                        // next filter value, so the shortest strobe still lands
                        xmov_rdata <= port0_filt_nxt;
                    end
                end
            end
        end
    end

    // on-chip RAM write lands at the end of the move
    always @(posedge sys_clk) begin
        if (state_r == `ST_INT && state_nxt == `ST_IDLE && mv_wr_r) begin
            xram_mem[mv_addr_r[`XRAM_AW-1:0]] <= mv_data_r;
        end
    end

    // pin drive follows the next sequencer step
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            port0_out <= 8'h00;
            port0_oe <= 8'h00;
            p2_out <= 8'h00;
            p2_oe <= 8'h00;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else if (state_nxt == `ST_EXT) begin
            ale <= (cnt_nxt < `ALE_CLKS);
            p2_out <= (state_r == `ST_IDLE) ? xmov_addr[15:8] : mv_addr_r[15:8];
            p2_oe <= 8'hFF;
            if (cnt_nxt < `MCYCLE_CLKS) begin
                // address phase, full push-pull drive
                port0_out <= (state_r == `ST_IDLE) ? xmov_addr[7:0] : mv_addr_r[7:0];
                port0_oe <= 8'hFF;
                rd_n <= 1'b1;
                wr_n <= 1'b1;
            end else begin
                // strobe stretched until the move's last clock, which has it released
                rd_n <= mv_wr_r | (cnt_nxt == total_r - 6'h01);
                wr_n <= ~mv_wr_r | (cnt_nxt == total_r - 6'h01);
                port0_out <= mv_data_r;
                port0_oe <= mv_wr_r ? 8'hFF : 8'h00;
            end
        end else begin
            // general I/O: open drain, only low is driven
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            port0_out <= 8'h00;
            port0_oe <= ~port0_latch_r;
            p2_out <= 8'h00;
            p2_oe <= 8'h00;
        end
    end

endmodule // data_memory_sfr_decode

// [src/data_memory_sfr_decode_map.vh]
// addresses, field positions, reset values and timing counts for the memory decoder
`ifndef DATA_MEMORY_SFR_DECODE_MAP_VH
`define DATA_MEMORY_SFR_DECODE_MAP_VH
`define SFR_PORT0_ADDR 8'h80
`define SFR_STACK_ADDR 8'h81
`define SFR_DPTR_LO_ADDR 8'h82
`define SFR_DPTR_HI_ADDR 8'h83
`define SFR_CLKCTL_ADDR 8'h8E
`define SFR_AUXPORT_ADDR 8'hA2
`define SFR_MEMMODE_ADDR 8'hC4
`define SFR_SPACE_BIT 7
`define BIT_NIBBLE_A 4'h0
`define BIT_NIBBLE_B 4'h8
`define XRAM_TOP 16'h03FF
`define XRAM_AW 10
`define XRAM_WORDS 1024
`define SCRATCH_WORDS 256
`define CODE_BANK_WORDS 65536
`define LOADER_WORDS 4096
`define LOADER_AW 12
`define BANK_APP_A 2'h0
`define BANK_APP_B 2'h1
`define BANK_LOADER 2'h2
`define XRAM_EN_BIT 0
`define PULLUP_EN_BIT 0
`define STRETCH_MSB 2
`define STRETCH_RST 3'h1
`define PORT0_RST 8'hFF
`define STACK_RST 8'h07
`define DPTR_RST 8'h00
`define UNIMPL_READ 8'hFF
`define MCYCLE_CLKS 6'h04
`define INT_MOVE_MCYCLES 6'h02
`define EXT_BASE_MCYCLES 6'h02
`define ALE_CLKS 6'h02
`define ST_IDLE 2'h0
`define ST_INT 2'h1
`define ST_EXT 2'h2
`endif

// [tb/ext_bus_model.sv]
// external memory on the multiplexed port 0/2 bus, with pin level resolution
`timescale 1ns/1ns
module ext_bus_model (
    input wire sys_clk,
    input wire [7:0] port0_out,
    input wire [7:0] port0_oe,
    input wire [7:0] p2_out,
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    input wire pull_en,
    input wire slow,
    output wire [7:0] port0_lvl
);
    reg [7:0] mem [0:65535];
    reg [15:0] addr_r = 16'h0000;
    reg [3:0] rd_cnt = 4'h0;
    reg flip = 1'b0;
    // slow mode answers two clocks into the read strobe
    wire drive = !rd_n && (!slow || rd_cnt >= 4'h2);
    // released pins float to a changing pattern unless pulled up
    wire [7:0] idle = pull_en ? 8'hFF : (flip ? 8'hA5 : 8'h5A);
    assign port0_lvl = (port0_oe & port0_out) | (~port0_oe & (drive ? mem[addr_r] : idle));
    always @(posedge sys_clk) begin
        flip <= ~flip;
        // stops at its top so a long strobe keeps the answer driven
        rd_cnt <= rd_n ? 4'h0 : (rd_cnt == 4'hF ? rd_cnt : rd_cnt + 4'h1);
        if (ale) begin
            addr_r <= {p2_out, port0_lvl};
        end
        if (!wr_n) begin
            mem[addr_r] <= port0_lvl;
        end
    end
endmodule // ext_bus_model

// [tb/data_memory_sfr_decode_sva.sv]
// timing and routing checker for the memory decoder
`timescale 1ns/1ns
module decode_checker (
    input wire sys_clk,
    input wire resetn,
    input wire [7:0] mem_addr,
    input wire mem_direct,
    input wire mem_rd,
    input wire mem_wr,
    input wire [7:0] mem_wdata,
    input wire mem_bit,
    input wire [7:0] mem_rdata,
    input wire xmov_req,
    input wire [15:0] xmov_addr,
    input wire xmov_busy,
    input wire xmov_done,
    input wire xmov_onchip,
    input wire [7:0] stack_pointer,
    input wire [7:0] port0_oe,
    input wire [7:0] p2_oe,
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    input wire port0_pullup_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire take = xmov_req && !xmov_busy;
    wire sfr_wr = mem_wr && mem_direct && !mem_bit;
    reg [7:0] cnt_r;
    reg [2:0] str_r;
    reg en_r;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= 8'h00;
            str_r <= 3'h1;
            en_r <= 1'b0;
        end else begin
            cnt_r <= take ? 8'h01 : (cnt_r == 8'hFF ? cnt_r : cnt_r + 8'h01);
            if (sfr_wr && mem_addr == 8'h8E) str_r <= mem_wdata[2:0];
            if (sfr_wr && mem_addr == 8'hC4) en_r <= mem_wdata[0];
        end
    end
    busy_follow_a: assert property (take |=> xmov_busy) else $error("busy missing");
    done_idle_a: assert property (xmov_done |-> !xmov_busy) else $error("busy at done");
    int_time_a: assert property (xmov_done && xmov_onchip |-> cnt_r == 8'h09)
        else $error("on-chip move length");
    ext_time_a: assert property (xmov_done && !xmov_onchip |->
        cnt_r == ({5'h00, str_r} + 8'h02) * 8'h04 + 8'h01) else $error("ext length");
    int_quiet_a: assert property (take && en_r && xmov_addr <= 16'h03FF |=>
        (!ale && rd_n && wr_n) [*7]) else $error("bus used for on-chip move");
    ext_route_a: assert property (take && !(en_r && xmov_addr <= 16'h03FF) |=> ale)
        else $error("ext move without latch strobe");
    bus_drive_a: assert property (ale |-> port0_oe == 8'hFF && p2_oe == 8'hFF)
        else $error("address not driven");
    read_free_a: assert property (!rd_n |-> port0_oe == 8'h00 && p2_oe == 8'hFF)
        else $error("read drive wrong");
    unimpl_read_a: assert property (mem_rd && mem_direct && !mem_bit && mem_addr == 8'h84
        |=> mem_rdata == 8'hFF) else $error("unimplemented read");
    pullup_set_a: assert property (sfr_wr && mem_addr == 8'hA2 |=>
        port0_pullup_enable == $past(mem_wdata[0])) else $error("pull-up bit");
    stack_wr_a: assert property (sfr_wr && mem_addr == 8'h81 |=>
        stack_pointer == $past(mem_wdata)) else $error("stack write");
    indirect_only_a: assert property (mem_wr && !mem_direct |=> $stable(stack_pointer))
        else $error("indirect reached register");
endmodule // decode_checker
bind data_memory_sfr_decode decode_checker chk (.sys_clk, .resetn, .mem_addr, .mem_direct,
    .mem_rd, .mem_wr, .mem_wdata, .mem_bit, .mem_rdata, .xmov_req, .xmov_addr, .xmov_busy,
    .xmov_done, .xmov_onchip, .stack_pointer, .port0_oe, .p2_oe, .ale, .rd_n, .wr_n,
    .port0_pullup_enable);

// [tb/tb.sv]
// self-checking bench for the memory decoder
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb;
    reg sys_clk = 1'b0, resetn = 1'b0, mem_direct = 1'b0, mem_rd = 1'b0, mem_wr = 1'b0;
    reg mem_bit = 1'b0, xmov_req = 1'b0, xmov_wr = 1'b0, code_rd = 1'b0, code_we = 1'b0;
    reg slow = 1'b0;
    reg [7:0] mem_addr = 8'h00, mem_wdata = 8'h00, xmov_wdata = 8'h00, code_wdata = 8'h00;
    reg [2:0] mem_bit_sel = 3'h0;
    reg [1:0] code_bank = 2'h0;
    reg [15:0] xmov_addr = 16'h0000, code_addr = 16'h0000;
    wire [7:0] mem_rdata, xmov_rdata, code_rdata, stack_pointer, port0_lvl, port0_out, port0_oe;
    wire [7:0] p2_out, p2_oe;
    wire [15:0] data_pointer;
    wire mem_rvalid, xmov_busy, xmov_done, xmov_onchip, ale, rd_n, wr_n, port0_pullup_enable;
    int tests_run = 0, n_fail = 0, cyc = 0, p, i, d;
    int sfr[int], msk[int], xram[int], ext[int];
    logic [15:0] ad [4] = '{16'h0000, 16'h03FF, 16'h0400, 16'hFFFF};
    logic [7:0] regs [7] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h8E, 8'hA2, 8'hC4};
    data_memory_sfr_decode uut (.sys_clk, .resetn, .mem_addr, .mem_direct, .mem_rd, .mem_wr,
        .mem_wdata, .mem_bit, .mem_bit_sel, .mem_rdata, .mem_rvalid, .xmov_req, .xmov_wr,
        .xmov_addr, .xmov_wdata, .xmov_busy, .xmov_done, .xmov_rdata, .xmov_onchip, .code_rd,
        .code_we, .code_bank, .code_addr, .code_wdata, .code_rdata, .stack_pointer,
        .data_pointer, .port0_in(port0_lvl), .port0_out, .port0_oe, .p2_out, .p2_oe, .ale,
        .rd_n, .wr_n, .port0_pullup_enable);
    ext_bus_model far (.sys_clk, .port0_out, .port0_oe, .p2_out, .ale, .rd_n, .wr_n,
        .pull_en(port0_pullup_enable), .slow, .port0_lvl);
    always #50 sys_clk = ~sys_clk;
    task stop_test;
        $display("checks %0d failures %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            stop_test;
        end
    end
    task mem_op(input wr, input [7:0] a, input dir, input b, input [2:0] s, input [7:0] w);
        @(posedge sys_clk);
        mem_addr <= a;
        mem_direct <= dir;
        mem_bit <= b;
        mem_bit_sel <= s;
        mem_wdata <= w;
        mem_wr <= wr;
        mem_rd <= !wr;
        @(posedge sys_clk);
        mem_wr <= 1'b0;
        mem_rd <= 1'b0;
        @(negedge sys_clk);
        if (!wr) `CHK("rvalid", 1'b1, mem_rvalid)
    endtask
    task sfr_wr(input [7:0] a, input [7:0] w);
        mem_op(1'b1, a, 1'b1, 1'b0, 3'h0, w);
        if (sfr.exists(a)) sfr[a] = w | msk[a];
    endtask
    task sfr_chk(input [7:0] a);
        mem_op(1'b0, a, 1'b1, 1'b0, 3'h0, 8'h00);
        `CHK("sfr", sfr.exists(a) ? sfr[a] : 8'hFF, mem_rdata)
    endtask
    task xmov(input w, input [15:0] a, input [7:0] v);
        int n;
        int onc;
        onc = (sfr[8'hC4] & 1) && a <= 16'h03FF;
        @(posedge sys_clk);
        xmov_req <= 1'b1;
        xmov_wr <= w;
        xmov_addr <= a;
        xmov_wdata <= v;
        @(posedge sys_clk);
        xmov_req <= 1'b0;
        // n counts clock edges after the one that took the request
        n = 0;
        @(negedge sys_clk);
        while (xmov_done !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("cycles", onc ? 8 : (2 + (sfr[8'h8E] & 7)) * 4, n)
        `CHK("onchip", onc[0], xmov_onchip)
        if (w && onc) xram[a] = v;
        else if (w) ext[a] = v;
        else `CHK("xdata", (onc ? xram[a] : ext[a]) & 8'hFF, xmov_rdata)
    endtask
    initial begin
        void'($urandom(78866));
        // reset values, unused bits read high
        sfr[8'h81] = 7;
        sfr[8'h82] = 0;
        sfr[8'h83] = 0;
        sfr[8'h8E] = 8'hF9;
        sfr[8'hA2] = 8'hFE;
        sfr[8'hC4] = 8'hFE;
        foreach (sfr[k]) msk[k] = 0;
        msk[8'h8E] = 8'hF8;
        msk[8'hA2] = 8'hFE;
        msk[8'hC4] = 8'hFE;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        `CHK("dptr", 16'h0000, data_pointer)
        `CHK("strobes", 3'b110, {rd_n, wr_n, port0_pullup_enable})
        foreach (regs[k]) begin
            sfr_chk(regs[k]);
            sfr_wr(regs[k], $urandom);
            sfr_chk(regs[k]);
        end
        `CHK("dptr", {sfr[8'h83][7:0], sfr[8'h82][7:0]}, data_pointer)
        `CHK("pullup", sfr[8'hA2][0], port0_pullup_enable)
        d = $urandom & 8'hFF;
        mem_op(1'b1, 8'h81, 1'b0, 1'b0, 3'h0, d);
        sfr_chk(8'h81);
        mem_op(1'b0, 8'h81, 1'b0, 1'b0, 3'h0, 8'h00);
        `CHK("scratch", d[7:0], mem_rdata)
        mem_op(1'b1, 8'h80, 1'b1, 1'b1, 3'h3, 8'h00);
        @(negedge sys_clk);
        `CHK("port0_oe", 8'h08, port0_oe)
        mem_op(1'b0, 8'h80, 1'b1, 1'b1, 3'h3, 8'h00);
        `CHK("bit", 8'h00, mem_rdata)
        mem_op(1'b0, 8'h81, 1'b1, 1'b1, 3'h0, 8'h00);
        `CHK("bit", 8'h01, mem_rdata)
        mem_op(1'b1, 8'h81, 1'b1, 1'b1, 3'h0, 8'h00);
        sfr_chk(8'h81);
        mem_op(1'b1, 8'h80, 1'b1, 1'b1, 3'h3, 8'h01);
        sfr_wr(8'h8E, 8'h01);
        for (p = 0; p < 3; p++) begin
            sfr_wr(8'hC4, {7'h00, p == 1});
            foreach (ad[k]) begin
                if (p < 2) xmov(1'b1, ad[k], $urandom);
                xmov(1'b0, ad[k], 8'h00);
            end
        end
        sfr_wr(8'h8E, 8'h00);
        xmov(1'b1, 16'h2000, $urandom);
        xmov(1'b0, 16'h2000, 8'h00);
        slow <= 1'b1;
        sfr_wr(8'h8E, 8'h07);
        xmov(1'b0, 16'h2000, 8'h00);
        for (i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            code_we <= i < 4;
            code_rd <= i >= 4;
            code_bank <= i[1:0];
            code_addr <= 16'h1234;
            code_wdata <= 8'h10 + i[7:0];
            @(negedge sys_clk);
            if (i > 4) `CHK("code", i < 8 ? 8'h0B + i[7:0] : 8'hFF, code_rdata)
        end
        @(posedge sys_clk);
        code_rd <= 1'b0;
        @(negedge sys_clk);
        `CHK("code", 8'hFF, code_rdata)
        stop_test;
    end
endmodule // tb
